// ---- src/serial_channel_uart.v ----
/*
 Receive/transmit channel pair of a serial array unit set up as an
 asynchronous link, with its port pin control.
 Assumes a synchronous register port, inputs already synchronous to
 mclk_in, and a prescaler that supplies two clock enables.
*/
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`include "serial_channel_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module serial_channel_uart #(
    parameter ADDR_W = 4
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    input wire prescaler_out_zero_in,
    input wire prescaler_out_one_in,
    input wire sck_in,
    input wire rxd_in,
    output reg txd_out,
    output reg txd_oe_out,
    output reg rxd_oe_out,
    output reg rx_done_out,
    output reg tx_irq_out,
    output reg rx_error_irq_out
);
    localparam S_IDLE = 4'h1;
    localparam S_WAIT = 4'h2;
    localparam S_RX = 4'h4;
    localparam S_TX = 4'h8;

    reg [15:0] rx_channel_mode_r;
    reg [15:0] rx_channel_comm_setting_r;
    reg [15:0] rx_channel_data_divider_r;
    reg [15:0] serial_output_level_r;
    reg [15:0] serial_output_enable_r;
    reg [7:0] port_output_latch_r;
    reg [7:0] port_direction_r;
    reg [8:0] tx_data_r;
    reg [8:0] rx_data_r;
    reg [3:0] state_r;
    reg channel_enable_status_r;
    reg [7:0] div_cnt_r;
    reg [12:0] shift_r;
    reg [3:0] bit_cnt_r;
    reg [3:0] frame_len_r;
    reg rx_prev_r;
    reg sck_prev_r;
    reg tx_line_r;
    reg parity_err_r;
    reg framing_err_r;

    wire [1:0] op_mode = {rx_channel_mode_r[`B_MDH], rx_channel_mode_r[`B_MDL]};
    wire [1:0] parity_cfg = {rx_channel_comm_setting_r[`B_PTH],
        rx_channel_comm_setting_r[`B_PTL]};
    wire [1:0] stop_cfg = {rx_channel_comm_setting_r[`B_SLH],
        rx_channel_comm_setting_r[`B_SLL]};
    wire [1:0] data_len = {rx_channel_comm_setting_r[`B_DLH],
        rx_channel_comm_setting_r[`B_DLL]};
    wire tx_enable_bit = rx_channel_comm_setting_r[`B_TXE];
    wire rx_enable_bit = rx_channel_comm_setting_r[`B_RXE];
    wire bit_order_sel = rx_channel_comm_setting_r[`B_DIR];
    wire [6:0] div_field = rx_channel_data_divider_r[`B_DIVH:`B_DIVL];

    wire [3:0] nbits = (data_len == `DL_9) ? 4'h9 :
        (data_len == `DL_7) ? 4'h7 : 4'h8;
    wire par_on = (parity_cfg != `PT_NONE);
    wire [1:0] nstop = (stop_cfg == `SL_TWO) ? 2'h2 :
        (stop_cfg == `SL_ONE) ? 2'h1 : 2'h0;

    wire op_tick = rx_channel_mode_r[`B_OPCLK] ? prescaler_out_one_in : prescaler_out_zero_in;
    // Divide by 2*(n+1); counter runs on op_tick
    wire div_end = op_tick && (div_cnt_r == {div_field, 1'b1});
    wire sck_rise = sck_in && !sck_prev_r;
    wire transfer_clock = rx_channel_mode_r[`B_CLKSRC] ? sck_rise : div_end;
    wire half_tick = op_tick && (div_cnt_r == {1'b0, div_field});

    wire start_edge = rx_channel_mode_r[`B_SIS] ? (rxd_in && !rx_prev_r) :
        (!rxd_in && rx_prev_r);

    // Parity over valid data bits only
    wire [8:0] dmask = (nbits == 4'h9) ? 9'h1ff : (nbits == 4'h8) ? 9'h0ff : 9'h07f;
    wire tx_par = (parity_cfg == `PT_ODD) ? ~^(tx_data_r & dmask) :
        (parity_cfg == `PT_EVEN) ? ^(tx_data_r & dmask) : 1'b0;

    reg [8:0] tx_ordered;
    integer i;
    always @* begin
        tx_ordered = 9'h000;
        for (i = 0; i < 9; i = i + 1) begin
            if (bit_order_sel || i >= nbits)
                tx_ordered[i] = tx_data_r[i];
            else
                tx_ordered[i] = tx_data_r[nbits - 1 - i];
        end
    end

    reg [8:0] rx_ordered;
    reg [8:0] rx_raw;
    reg rx_par_bit;
    reg rx_par_ok;
    integer j;
    always @* begin
        rx_raw = 9'h000;
        rx_ordered = 9'h000;
        for (j = 0; j < 9; j = j + 1) begin
            if (j < nbits)
                rx_raw[j] = shift_r[j];
        end
        for (j = 0; j < 9; j = j + 1) begin
            if (j < nbits)
                rx_ordered[j] = bit_order_sel ? rx_raw[j] : rx_raw[nbits - 1 - j];
        end
        rx_par_bit = shift_r[nbits];
        rx_par_ok = (parity_cfg == `PT_EVEN) ? (^rx_ordered == rx_par_bit) :
            (parity_cfg == `PT_ODD) ? (~^rx_ordered == rx_par_bit) : 1'b1;
    end

    wire uart_mode = (op_mode == `MD_UART);
    wire [3:0] rx_len = nbits + {3'h0, par_on};
    wire [3:0] tx_len = 4'h1 + nbits + {3'h0, par_on} + {2'h0, nstop};
    wire wr_start = wr_in && (addr_in == `OFS_START) && wdata_in[0];
    wire wr_tx = wr_in && (addr_in == `OFS_TXDATA);

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rx_channel_mode_r <= `RST_MODE;
            rx_channel_comm_setting_r <= `RST_COMM;
            rx_channel_data_divider_r <= `RST_DIV;
            serial_output_level_r <= `RST_OLVL;
            serial_output_enable_r <= `RST_OEN;
            port_output_latch_r <= `RST_LATCH;
            port_direction_r <= `RST_DIR;
            tx_data_r <= 9'h000;
            rx_data_r <= 9'h000;
            state_r <= S_IDLE;
            channel_enable_status_r <= 1'b0;
            div_cnt_r <= 8'h00;
            shift_r <= 13'h0000;
            bit_cnt_r <= 4'h0;
            frame_len_r <= 4'h0;
            rx_prev_r <= 1'b1;
            sck_prev_r <= 1'b0;
            tx_line_r <= 1'b1;
            parity_err_r <= 1'b0;
            framing_err_r <= 1'b0;
            rdata_out <= `ZERO16;
            txd_out <= 1'b1;
            txd_oe_out <= 1'b0;
            rxd_oe_out <= 1'b0;
            rx_done_out <= 1'b0;
            tx_irq_out <= 1'b0;
            rx_error_irq_out <= 1'b0;
        end else begin
            rx_prev_r <= rxd_in;
            sck_prev_r <= sck_in;
            rx_done_out <= 1'b0;
            tx_irq_out <= 1'b0;
            rx_error_irq_out <= 1'b0;
            if (wr_in) begin
                case (addr_in)
                    `OFS_MODE: rx_channel_mode_r <= wdata_in;
                    `OFS_COMM: rx_channel_comm_setting_r <= wdata_in;
                    `OFS_DIV: rx_channel_data_divider_r <= wdata_in;
                    `OFS_OLVL: serial_output_level_r <= wdata_in;
                    `OFS_OEN: serial_output_enable_r <= wdata_in;
                    `OFS_LATCH: port_output_latch_r <= wdata_in[7:0];
                    `OFS_DIR: port_direction_r <= wdata_in[7:0];
                    `OFS_TXDATA: tx_data_r <= wdata_in[8:0];
                    default: ;
                endcase
            end
            // Unmapped reads return zero
            rdata_out <= `ZERO16;
            if (rd_in) begin
                case (addr_in)
                    `OFS_MODE: rdata_out <= rx_channel_mode_r;
                    `OFS_COMM: rdata_out <= rx_channel_comm_setting_r;
                    `OFS_DIV: rdata_out <= rx_channel_data_divider_r;
                    `OFS_OLVL: rdata_out <= serial_output_level_r;
                    `OFS_OEN: rdata_out <= serial_output_enable_r;
                    `OFS_LATCH: rdata_out <= {8'h00, port_output_latch_r};
                    `OFS_DIR: rdata_out <= {8'h00, port_direction_r};
                    `OFS_STATUS: rdata_out <= {12'h000, framing_err_r, parity_err_r,
                        state_r == S_WAIT, channel_enable_status_r};
                    `OFS_RXDATA: rdata_out <= {7'h00, rx_data_r};
                    default: rdata_out <= `ZERO16;
                endcase
            end
            // Divider phase restarts with each frame
            if (state_r == S_WAIT)
                div_cnt_r <= 8'h00;
            else if (div_end)
                div_cnt_r <= 8'h00;
            else if (op_tick)
                div_cnt_r <= div_cnt_r + 8'h01;
            case (state_r)
                S_IDLE: begin
                    if (wr_start) begin
                        channel_enable_status_r <= 1'b1;
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (uart_mode && rx_enable_bit && rx_channel_mode_r[`B_STS] && start_edge) begin
                        bit_cnt_r <= 4'h0;
                        frame_len_r <= rx_len;
                        shift_r <= 13'h0000;
                        state_r <= S_RX;
                    end else if (tx_enable_bit && !rx_channel_mode_r[`B_STS] && wr_tx) begin
                        shift_r <= {2'h3, 1'b1, 10'h000} | ({4'h0, wdata_in[8:0]} << 1);
                        bit_cnt_r <= 4'h0;
                        frame_len_r <= tx_len;
                        state_r <= S_TX;
                    end
                end
                S_RX: begin
                    // Sampling at mid bit avoids edge jitter
                    if (half_tick) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        // Slot 0 is the start bit, not stored
                        if (bit_cnt_r != 4'h0 && bit_cnt_r <= frame_len_r)
                            shift_r[bit_cnt_r - 4'h1] <= rxd_in ^ rx_channel_mode_r[`B_SIS];
                        // Last slot is the stop bit
                        if (bit_cnt_r == frame_len_r + 4'h1) begin
                            state_r <= S_WAIT;
                            rx_data_r <= rx_ordered;
                            parity_err_r <= !rx_par_ok;
                            framing_err_r <= (nstop != 2'h0) &&
                                !(rxd_in ^ rx_channel_mode_r[`B_SIS]);
                            rx_done_out <= 1'b1;
                            rx_error_irq_out <= rx_channel_comm_setting_r[`B_EOC] &&
                                (!rx_par_ok || ((nstop != 2'h0) &&
                                !(rxd_in ^ rx_channel_mode_r[`B_SIS])));
                        end
                    end
                end
                S_TX: begin
                    if (bit_cnt_r == 4'h0 && transfer_clock) begin
                        tx_line_r <= 1'b0;
                        // Parity sits right after the last data bit
                        shift_r <= {4'hf, tx_ordered & dmask} | ({12'h000, tx_par} << nbits);
                        bit_cnt_r <= 4'h1;
                        tx_irq_out <= rx_channel_mode_r[`B_IRQSRC];
                    end else if (transfer_clock) begin
                        tx_line_r <= (bit_cnt_r > nbits + {3'h0, par_on}) ? 1'b1 :
                            shift_r[bit_cnt_r - 4'h1];
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == frame_len_r || bit_cnt_r == `MAX_BITS) begin
                            tx_line_r <= 1'b1;
                            state_r <= S_WAIT;
                            tx_irq_out <= !rx_channel_mode_r[`B_IRQSRC];
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
            // Level bit drives output when idle if output enable bit 0 is set; with it clear the port latch bit drives it
            if (serial_output_enable_r[0] && state_r == S_TX)
                txd_out <= tx_line_r;
            else if (serial_output_enable_r[0])
                txd_out <= serial_output_level_r[0];
            else
                txd_out <= port_output_latch_r[`B_TXPIN];
            txd_oe_out <= !port_direction_r[`B_TXPIN];
            rxd_oe_out <= !port_direction_r[`B_RXPIN];
        end
    end
endmodule

`default_nettype wire

// ---- src/serial_channel_defs.vh ----
/*
 Constants for the serial channel block: register offsets, field
 positions, encodings and timing counts.
 Assumes inclusion by bare name from the design file.
*/
`ifndef SERIAL_CHANNEL_DEFS_VH
`define SERIAL_CHANNEL_DEFS_VH

// Register offsets
`define OFS_MODE 4'h0
`define OFS_COMM 4'h1
`define OFS_DIV 4'h2
`define OFS_OLVL 4'h3
`define OFS_OEN 4'h4
`define OFS_LATCH 4'h5
`define OFS_DIR 4'h6
`define OFS_START 4'h7
`define OFS_STATUS 4'h8
`define OFS_RXDATA 4'h9
`define OFS_TXDATA 4'ha

// Mode register fields
`define B_OPCLK 15
`define B_CLKSRC 14
`define B_STS 8
`define B_SIS 6
`define B_MDH 2
`define B_MDL 1
`define B_IRQSRC 0

// Comm register fields
`define B_TXE 15
`define B_RXE 14
`define B_EOC 10
`define B_PTH 9
`define B_PTL 8
`define B_DIR 7
`define B_SLH 5
`define B_SLL 4
`define B_DLH 1
`define B_DLL 0

// Divider field
`define B_DIVH 15
`define B_DIVL 9

// Port bits
`define B_TXPIN 1
`define B_RXPIN 0

// Encodings
`define MD_CSI 2'h0
`define MD_UART 2'h1
`define MD_IIC 2'h2
`define PT_NONE 2'h0
`define PT_ZERO 2'h1
`define PT_EVEN 2'h2
`define PT_ODD 2'h3
`define DL_9 2'h1
`define DL_7 2'h2
`define DL_8 2'h3
`define SL_NONE 2'h0
`define SL_ONE 2'h1
`define SL_TWO 2'h2

// Reset values
`define RST_MODE 16'h0020
`define RST_COMM 16'h0087
`define RST_DIV 16'h0000
`define RST_OLVL 16'h0001
`define RST_OEN 16'h0000
`define RST_LATCH 8'hff
`define RST_DIR 8'hff

// Frame limit and zero word
`define MAX_BITS 4'hd
`define ZERO16 16'h0000

`endif

// ---- bench/serial_channel_uart_chk.sv ----
/* Port-level checker for serial_channel_uart.
   Assumes it is bound onto that module and shares its constants header. */
`include "serial_channel_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module serial_channel_uart_chk #(
    parameter ADDR_W = 4
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [15:0] rdata_out,
    input wire txd_oe_out,
    input wire rxd_oe_out,
    input wire rx_done_out,
    input wire tx_irq_out,
    input wire rx_error_irq_out
);
    localparam logic [15:0] RC = `RST_COMM;
    logic eoc_r;
    logic started_r;
    logic [7:0] dir_r;
    wire dir_wr = wr_in && (addr_in == `OFS_DIR);
    // Shadow of what software wrote, so no design internals are needed
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            eoc_r <= RC[`B_EOC];
            started_r <= 1'b0;
            dir_r <= `RST_DIR;
        end else if (wr_in) begin
            if (addr_in == `OFS_COMM) begin
                eoc_r <= wdata_in[`B_EOC];
            end
            if (addr_in == `OFS_START && wdata_in[0]) begin
                started_r <= 1'b1;
            end
            if (dir_wr) begin
                dir_r <= wdata_in[7:0];
            end
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // Two quiet cycles let a registered pin enable catch up
    sequence s_dir_quiet;
        !dir_wr [*2];
    endsequence
    property p_rdata_idle;
        !rd_in |=> rdata_out == 16'h0000;
    endproperty
    property p_dir_read;
        rd_in && addr_in == `OFS_DIR |=> rdata_out[7:0] == $past(dir_r);
    endproperty
    property p_txoe;
        s_dir_quiet |-> txd_oe_out == !dir_r[`B_TXPIN];
    endproperty
    property p_rxoe;
        s_dir_quiet |-> rxd_oe_out == !dir_r[`B_RXPIN];
    endproperty
    property p_err_masked;
        !eoc_r && !$past(eoc_r) |-> !rx_error_irq_out;
    endproperty
    property p_done_started;
        rx_done_out |-> started_r;
    endproperty
    property p_tx_started;
        tx_irq_out |-> started_r;
    endproperty
    property p_done_pulse;
        rx_done_out |=> !rx_done_out;
    endproperty
    property p_err_pulse;
        rx_error_irq_out |=> !rx_error_irq_out;
    endproperty
    property p_txirq_pulse;
        tx_irq_out |=> !tx_irq_out;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
    a_dir_read: assert property (p_dir_read) else $error("direction read back wrong");
    a_txoe: assert property (p_txoe) else $error("tx pin enable wrong");
    a_rxoe: assert property (p_rxoe) else $error("rx pin enable wrong");
    a_err_masked: assert property (p_err_masked) else $error("masked error fired");
    a_done_started: assert property (p_done_started) else $error("frame before start");
    a_tx_started: assert property (p_tx_started) else $error("tx end before start");
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
    a_err_pulse: assert property (p_err_pulse) else $error("error longer than a cycle");
    a_txirq_pulse: assert property (p_txirq_pulse) else $error("tx irq longer than a cycle");
endmodule
bind serial_channel_uart serial_channel_uart_chk #(.ADDR_W(ADDR_W)) chk_u (
    .mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .txd_oe_out, .rxd_oe_out, .rx_done_out, .tx_irq_out, .rx_error_irq_out);
`default_nettype wire

// ---- bench/remote_uart.sv ----
/* Far-end asynchronous transmitter and receiver model.
   Assumes the bench sets its frame settings before each use. */
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
    input wire logic clk_in,
    input wire logic txd_in,
    output logic rxd_out,
    output logic got_out,
    output logic [10:0] got_data_out
);
    int bit_cyc = 8;
    int nbits = 8;
    logic [1:0] par = 2'h0;
    logic lsb = 1'b0;
    logic listen = 1'b0;
    initial begin
        rxd_out = 1'b1;
        got_out = 1'b0;
        got_data_out = 11'h000;
    end
    function automatic logic par_bit(input logic [8:0] d);
        return (par == 2'h1) ? 1'b0 : ((^d) ^ (par == 2'h3));
    endfunction
    task automatic drive(input logic v);
        @(posedge clk_in);
        rxd_out <= v;
        repeat (bit_cyc - 1) @(posedge clk_in);
    endtask
    task automatic send(input logic [8:0] d, input logic flip);
        drive(1'b0);
        for (int i = 0; i < nbits; i++) drive(d[lsb ? i : nbits - 1 - i]);
        if (par != 2'h0) drive(par_bit(d) ^ flip);
        drive(1'b1);
    endtask
    // mid-bit sampling; stop level kept in top bit
    always begin
        logic [10:0] w;
        @(posedge clk_in);
        if (listen && txd_in === 1'b0) begin
            w = 11'h000;
            repeat (bit_cyc / 2) @(posedge clk_in);
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_cyc) @(posedge clk_in);
                w[lsb ? i : nbits - 1 - i] = txd_in;
            end
            if (par != 2'h0) begin
                repeat (bit_cyc) @(posedge clk_in);
                w[9] = txd_in;
            end
            repeat (bit_cyc) @(posedge clk_in);
            w[10] = txd_in;
            got_data_out <= w;
            got_out <= 1'b1;
            @(posedge clk_in);
            got_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
/* Self-checking bench for serial_channel_uart with a far-end model.
   Assumes the checker is bound in and the constants header is visible. */
`include "serial_channel_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pz = 1'b1, po = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic rxd, txd, txd_oe, rxd_oe, rx_done, tx_irq, rx_err, got, rd_q = 1'b0;
    logic [10:0] got_data;
    int miscompares = 0;
    int checked = 0;
    int done_cnt = 0, err_cnt = 0, txirq_cnt = 0, got_cnt = 0;
    logic [15:0] q_rd[$];
    logic [15:0] q_msk[$];
    logic [10:0] q_tx[$];
    logic [15:0] rst_v[7] = '{`RST_MODE, `RST_COMM, `RST_DIV, `RST_OLVL, `RST_OEN,
        {8'h00, `RST_LATCH}, {8'h00, `RST_DIR}};
    logic [15:0] rxc[6] = '{16'h34c4, 16'h3568, 16'h14b4, 16'h1dd0, 16'h37e4, 16'h32f4};
    always #25 mclk = ~mclk;
    // Second prescaler output at half rate
    always @(posedge mclk) po <= ~po;
    serial_channel_uart dut_u (.mclk_in(mclk), .rst_n_in(rst_n), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .prescaler_out_zero_in(pz), .prescaler_out_one_in(po), .sck_in(1'b0),
        .rxd_in(rxd), .txd_out(txd), .txd_oe_out(txd_oe), .rxd_oe_out(rxd_oe),
        .rx_done_out(rx_done), .tx_irq_out(tx_irq), .rx_error_irq_out(rx_err));
    remote_uart far_u (.clk_in(mclk), .txd_in(txd), .rxd_out(rxd), .got_out(got),
        .got_data_out(got_data));
    task automatic end_sim();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        cmp({15'h0, g}, {15'h0, e});
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        q_rd.push_back(e & m);
        q_msk.push_back(m);
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask
    // Results are taken off the queues as they appear
    always @(negedge mclk) begin
        if (rd_q) cmp(rdata & q_msk.pop_front(), q_rd.pop_front());
        if (got === 1'b1) cmp({5'h0, got_data}, {5'h0, q_tx.pop_front()});
        rd_q = rd;
    end
    always @(posedge mclk) begin
        if (rx_done === 1'b1) done_cnt++;
        if (rx_err === 1'b1) err_cnt++;
        if (tx_irq === 1'b1) txirq_cnt++;
        if (got === 1'b1) got_cnt++;
    end
    function automatic int len_of(input logic [1:0] dl);
        return (dl == 2'h1) ? 9 : ((dl == 2'h2) ? 7 : 8);
    endfunction
    task automatic setup(input logic [15:0] c, input logic sts, input logic txe,
        input logic go);
        logic [15:0] m;
        logic [15:0] s;
        m = {c[11], 6'h00, sts, 3'b001, 2'b00, 2'b01, 1'b0};
        s = {txe, ~txe, 3'h0, c[10], c[5:4], c[8], 1'b0, c[3:2], 2'b01, c[7:6]};
        wr_reg(`OFS_MODE, m);
        wr_reg(`OFS_COMM, s);
        wr_reg(`OFS_DIV, {3'h0, c[15:12], 9'h000});
        rd_reg(`OFS_MODE, m, 16'hffff);
        rd_reg(`OFS_COMM, s, 16'hffff);
        far_u.bit_cyc = 2 * (c[15:12] + 1) * (c[11] ? 2 : 1);
        far_u.nbits = len_of(c[7:6]);
        far_u.par = c[5:4];
        far_u.lsb = c[8];
        repeat (4) @(posedge mclk);
        if (go) wr_reg(`OFS_START, 16'h0001);
    endtask
    task automatic rx_case(input logic [15:0] c, input logic go);
        logic [8:0] d;
        int d0, e0;
        d = 9'($urandom()) & 9'((1 << len_of(c[7:6])) - 1);
        setup(c, 1'b1, 1'b0, go);
        if (go) rd_reg(`OFS_STATUS, 16'h0003, 16'h0003);
        d0 = done_cnt;
        e0 = err_cnt;
        far_u.send(d, c[9]);
        for (int i = 0; i < 40 && done_cnt == d0; i++) @(posedge mclk);
        settle();
        if (!c[9]) cmp(16'(done_cnt - d0), {15'h0, go});
        cmp(16'(err_cnt - e0), {15'h0, c[9] & c[10]});
        if (go && !c[9]) rd_reg(`OFS_RXDATA, {7'h0, d}, 16'hffff);
    endtask
    task automatic tx_case(input logic [15:0] c, input logic txe);
        logic [8:0] d;
        int t0, g0;
        d = 9'($urandom()) & 9'((1 << len_of(c[7:6])) - 1);
        setup(c, 1'b0, txe, 1'b1);
        if (txe) q_tx.push_back({1'b1, (c[5:4] == 2'h2) ? ^d : ((c[5:4] == 2'h3) ? ~^d : 1'b0), d});
        t0 = txirq_cnt;
        g0 = got_cnt;
        wr_reg(`OFS_TXDATA, {7'h0, d});
        for (int i = 0; i < 400 && got_cnt == g0; i++) @(posedge mclk);
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        cmp(16'(txirq_cnt - t0), {15'h0, txe});
    endtask
    initial begin
        #1ms;
        miscompares++;
        end_sim();
    end
    initial begin
        void'($urandom(24));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk1(txd, 1'b1);
        chk1(txd_oe, 1'b0);
        for (int i = 0; i < 7; i++) rd_reg(4'(i), rst_v[i], 16'hffff);
        rd_reg(4'hf, 16'h0000, 16'hffff);
        wr_reg(`OFS_DIR, 16'h00fc);
        settle();
        chk1(rxd_oe, 1'b1);
        wr_reg(`OFS_DIR, 16'h00fd);
        rd_reg(`OFS_DIR, 16'h00fd, 16'h00ff);
        for (int i = 0; i < 4; i++) begin
            wr_reg(`OFS_LATCH, {14'h0, i[1], 1'b0});
            wr_reg(`OFS_OLVL, {15'h0, i[0]});
            settle();
            chk1(txd, i[1]);
            chk1(txd_oe, 1'b1);
        end
        // No start written yet, so this frame must be ignored
        rx_case(16'h34c4, 1'b0);
        foreach (rxc[i]) rx_case(rxc[i], 1'b1);
        far_u.listen = 1'b1;
        wr_reg(`OFS_OEN, 16'h0001);
        tx_case(16'h31e4, 1'b0);
        tx_case(16'h31e4, 1'b1);
        tx_case(16'h1088, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
